// >>> bench/safety_relay_model.sv
/* external safety relay: opens each channel on request.
   assumes requests come from the bench on clk. */
`timescale 1ns/1ps
module safety_relay_model (
   // request and clock
   input wire logic clk,
   input wire logic [1:0] open_req,
   // channel outputs
   output logic chan_a,
   output logic chan_b
);
   // both contacts move on one edge, so a joint demand never looks like a fault
   always_ff @(posedge clk) begin
      chan_a <= !open_req[1];
      chan_b <= !open_req[0];
   end
endmodule : safety_relay_model

// >>> bench/tb.sv
/* bench for the torque cutoff monitor: table of cases, then fault checks.
   assumes a short discrepancy count of 20 cycles. */
`timescale 1ns/1ps
module tb;
   import torque_cutoff_pkg::*;
   logic clk, rstn, a, b, done;
   logic [1:0] req;
   drive_cmd_t cmd;
   drive_stat_t stat;
   logic [15:0] spd;
   logic [15:0] sp;
   int fails, n_checks;
   // open request, start, stop, ramp done, then status and speed
   logic [24:0] rows [9] = '{25'h0481234, 25'h1020000, 25'h0000000, 25'h0481234, 25'h0820000,
      25'h0481234, 25'h02C1234, 25'h0100000, 25'h1820000};
   safety_relay_model relay (.clk(clk), .open_req(req), .chan_a(a), .chan_b(b));
   torque_cutoff_monitor #(.DISCREP_CYCLES(20)) uut (.clk(clk), .rstn(rstn), .torque_enable_chan_a(a),
      .torque_enable_chan_b(b), .cmd(cmd), .test_speed_setpoint(sp), .decel_done(done), .stat(stat),
      .speed_ref(spd));
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   task chk(string nm, logic [15:0] e, logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   // inputs change on the edge; sampling waits 1 ns for outputs to settle
   task step(logic [4:0] in, int n);
      @(posedge clk);
      {req, cmd, done} <= in;
      repeat (n - 1) @(posedge clk);
      #1;
   endtask : step
   task end_sim;
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : end_sim
   initial begin
      #10000;
      fails++;
      end_sim;
   end
   initial begin
      rstn = 0;
      req = 0;
      cmd = 0;
      done = 0;
      sp = 16'h1234;
      repeat (6) @(posedge clk);
      rstn <= 1;
      foreach (rows[i]) begin
         step(rows[i][24:20], 4);
         chk("stat", 16'(rows[i][19:16]), 16'(stat));
         chk("speed", rows[i][15:0], spd);
      end
      // one channel held open past the limit, channel a then b
      for (int k = 0; k < 2; k++) begin
         if (k) begin
            @(posedge clk);
            sp <= 16'h4321;
         end
         step(5'h00, 4);
         chk("held", k ? 16'h1234 : 16'h0000, spd);
         step(5'h04, 4);
         step(k ? 5'h08 : 5'h10, 30);
         chk("latch", 16'h0003, 16'(stat));
         step(5'h04, 6);
         chk("locked", 16'h0003, 16'(stat));
         @(posedge clk);
         rstn <= 0;
         step(5'h04, 2);
         @(posedge clk);
         rstn <= 1;
         step(5'h04, 4);
         chk("restart", k ? 16'h4321 : 16'h1234, spd);
      end
      step(5'h18, 40);
      chk("both_off", 16'h0002, 16'(stat));
      step(5'h00, 4);
      chk("idle", 16'h0000, 16'(stat));
      end_sim;
   end
endmodule : tb

// >>> bench/torque_cutoff_assertions.sv
/* checker for the torque cutoff monitor, bound to its ports.
   assumes one clock and rstn as power cycle. */
`timescale 1ns/1ps
module torque_cutoff_checker
   import torque_cutoff_pkg::*;
#(parameter longint unsigned DISCREP_CYCLES = 20) (
   // clock, reset, channels
   input wire logic clk,
   input wire logic rstn,
   input wire logic torque_enable_chan_a,
   input wire logic torque_enable_chan_b,
   // command side
   input wire drive_cmd_t cmd,
   input wire logic [15:0] test_speed_setpoint,
   // status side
   input wire drive_stat_t stat,
   input wire logic [15:0] speed_ref
);
   wire logic ok = torque_enable_chan_a & torque_enable_chan_b;
   wire logic dis = torque_enable_chan_a ^ torque_enable_chan_b;
   longint unsigned dc_ff;
   // disagreement run length, kept here so latch timing needs no long repetition
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) dc_ff <= 0;
      else dc_ff <= dis ? dc_ff + 1 : 0;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   a_drop_trips: assert property (stat.power_on && !ok |=> stat.trip && !stat.power_on)
      else $error("no cutoff after channel loss");
   a_trip_clears: assert property (stat.trip && !stat.fault_latch && ok |=> !stat.trip)
      else $error("trip kept with both channels back");
   a_start_runs: assert property (!stat.power_on && !stat.trip && ok && cmd.start
      |=> stat.power_on && speed_ref == $past(test_speed_setpoint))
      else $error("start refused or wrong speed");
   a_stop_decel: assert property (stat.power_on && !stat.decel && ok && cmd.stop |=> stat.decel && stat.power_on)
      else $error("stop did not ramp down");
   a_latch_holds: assert property (stat.fault_latch |=> stat.fault_latch && stat.trip)
      else $error("latch dropped without power cycle");
   a_lock_no_power: assert property (stat.fault_latch |-> !stat.power_on)
      else $error("motor powered while latched");
   a_latch_due: assert property (dc_ff > DISCREP_CYCLES + 2 |-> stat.fault_latch)
      else $error("latch missing after long disagreement");
   a_latch_early: assert property ($rose(stat.fault_latch) |-> dc_ff >= DISCREP_CYCLES)
      else $error("latch set too early");
endmodule : torque_cutoff_checker
bind torque_cutoff_monitor torque_cutoff_checker #(.DISCREP_CYCLES(DISCREP_CYCLES)) chk (.*);

// >>> core/torque_cutoff_monitor.sv
/*
 * torque_cutoff_monitor: dual-channel safe torque cutoff supervisor.
 * Holds the drive state machine (idle, run, controlled deceleration,
 * coast after a cutoff, locked after a channel discrepancy), the
 * discrepancy timer with its fault latch, and the registered status
 * and speed reference handed to motor control.
 * Assumes enable inputs are already synchronous to clk and that a full
 * power cycle of the device is seen as rstn low.
 * Assumes motor control raises decel_done once the ramp reaches rest.
 */
// Functional notes
// - Channel A drop while running: coast, trip
// - Channel B drop while running: coast, trip
// - Both channels back: trip clears, restart allowed
// - Channel A alone low over 3 s latches
// - Channel B alone low over 3 s latches
// - Latch holds trip and refuses any start
// - Only power cycle clears latch
// - Stop command with enables: controlled deceleration
// - Power removed within 15 ms of change
`timescale 1ns/1ps
module torque_cutoff_monitor
   import torque_cutoff_pkg::*;
#(
   parameter longint unsigned DISCREP_CYCLES = DISCREP_CYCLES_L,
   parameter int unsigned SPEED_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // safety enable channels
   input wire logic torque_enable_chan_a,
   input wire logic torque_enable_chan_b,
   // operator command and setpoint
   input wire drive_cmd_t cmd,
   input wire logic [SPEED_W-1:0] test_speed_setpoint,
   // decel ramp finished, reported by motor control
   input wire logic decel_done,
   // outputs
   output drive_stat_t stat,
   output logic [SPEED_W-1:0] speed_ref
);

   localparam int CNT_W = $clog2(DISCREP_CYCLES + 2);
   // cut is registered on the same edge that samples the channel change
   localparam longint unsigned CUT_LATENCY = 64'd1;

   // elaboration checks: the timer needs a real limit, the speed path at
   // least one bit, and the one-cycle cut must fit inside the removal bound
   if (DISCREP_CYCLES < 1) begin : g_bad_limit
      $error("torque_cutoff_monitor: discrepancy limit must be at least one cycle");
   end
   if (SPEED_W < 1) begin : g_bad_width
      $error("torque_cutoff_monitor: speed width must be at least one bit");
   end
   if (CNT_W > 63) begin : g_bad_count
      $error("torque_cutoff_monitor: discrepancy limit too large for the timer");
   end
   if (CUT_LATENCY >= CUTOFF_CYCLES_L) begin : g_bad_cutoff
      $error("torque_cutoff_monitor: cut latency exceeds power removal bound");
   end

   // channel view, index 0 is channel a
   logic [1:0] chan_in;
   logic [1:0] chan_low;
   logic both_on;
   logic disagree;

   // drive state group
   drive_state_t state_ff;
   drive_state_t nxt_state;

   // discrepancy timer group
   logic [CNT_W-1:0] cnt_ff;
   logic [CNT_W-1:0] nxt_cnt;
   logic latch_ff;
   logic nxt_latch;

   // output group
   drive_stat_t stat_ff;
   drive_stat_t nxt_stat;
   logic [SPEED_W-1:0] speed_ff;
   logic [SPEED_W-1:0] nxt_speed;

   // pack the two pins so both channels go through the same logic
   assign chan_in = {torque_enable_chan_b, torque_enable_chan_a};

   // per-channel loss detect; both channels are treated alike so that
   // neither one can mask a loss on the other
   for (genvar i = 0; i < 2; i++) begin : g_chan
      assign chan_low[i] = !chan_in[i];
   end

   // both enabled permits running; exactly one low is a discrepancy
   assign both_on = ~|chan_low;
   assign disagree = ^chan_low;

   // discrepancy timer and fault latch; saturating so it never wraps, and
   // cleared when both channels agree so a joint demand never latches
   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_latch = latch_ff;
      if (disagree) begin
         if (cnt_ff != CNT_W'(DISCREP_CYCLES)) begin
            nxt_cnt = cnt_ff + CNT_W'(1);
         end else begin
            nxt_latch = 1'b1;
         end
      end else begin
         nxt_cnt = '0;
      end
      // latch never clears here; only reset does
   end

   // timer registers; the latch is cleared only by power-up reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         cnt_ff <= '0;
         latch_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         latch_ff <= nxt_latch;
      end
   end

   // drive state machine:
   //    idle   - powered down, waiting for a start with both channels on
   //    run    - motor powered at the captured setpoint
   //    decel  - controlled ramp to rest after a stop command
   //    coast  - torque cut after a channel loss, motor spins down freely
   //    locked - discrepancy latched; nothing leaves this state but reset
   // the next latch value is used so the lock takes effect on the same
   // edge as the latch itself, leaving no cycle in which a start slips in
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE: begin
            if (nxt_latch) begin
               nxt_state = ST_LOCKED;
            end else if (!both_on) begin
               nxt_state = ST_COAST;
            end else if (cmd.start) begin
               nxt_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (nxt_latch) begin
               nxt_state = ST_LOCKED;
            end else if (!both_on) begin
               nxt_state = ST_COAST;
            end else if (cmd.stop) begin
               nxt_state = ST_DECEL;
            end
         end
         ST_DECEL: begin
            if (nxt_latch) begin
               nxt_state = ST_LOCKED;
            end else if (!both_on) begin
               nxt_state = ST_COAST;
            end else if (decel_done) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_COAST: begin
            if (nxt_latch) begin
               nxt_state = ST_LOCKED;
            end else if (both_on) begin
               nxt_state = ST_IDLE;
            end
         end
         ST_LOCKED: begin
            // start, stop and channel return are all ignored here
            nxt_state = ST_LOCKED;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= ST_IDLE;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // registered outputs derived from the next state so torque cuts
   // on the edge after the channel change, far inside the bound
   always_comb begin
      nxt_stat.power_on = (nxt_state == ST_RUN) || (nxt_state == ST_DECEL);
      nxt_stat.decel = (nxt_state == ST_DECEL);
      nxt_stat.trip = (nxt_state == ST_COAST) || (nxt_state == ST_LOCKED);
      nxt_stat.fault_latch = nxt_latch;
      nxt_speed = speed_ff;
      // setpoint is captured once on entry, so a change while running
      // does not move the motor until the next start
      if (nxt_state == ST_RUN && state_ff != ST_RUN) begin
         nxt_speed = test_speed_setpoint;
      end else if (nxt_state != ST_RUN && nxt_state != ST_DECEL) begin
         nxt_speed = '0;
      end
   end

   // output registers; all outputs read zero during power-up reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         stat_ff <= '0;
         speed_ff <= '0;
      end else begin
         stat_ff <= nxt_stat;
         speed_ff <= nxt_speed;
      end
   end

   // ports come straight from the output flops
   assign stat = stat_ff;
   assign speed_ref = speed_ff;

endmodule : torque_cutoff_monitor

// >>> core/torque_cutoff_pkg.sv
/*
 * torque_cutoff_pkg: constants and carrier types for the dual-channel
 * torque cutoff monitor.
 * Assumes a single 200 MHz clock domain.
 */
package torque_cutoff_pkg;

   // clock rate
   localparam int unsigned CLK_PERIOD_PS = 5000;

   // discrepancy limit, in milliseconds
   localparam longint unsigned DISCREP_TIME_MS = 3000;
   localparam longint unsigned DISCREP_CYCLES_L = (DISCREP_TIME_MS * 64'd1000000000) / CLK_PERIOD_PS;

   // power removal bound, in microseconds; cut is applied within one cycle
   localparam longint unsigned CUTOFF_TIME_US = 15000;
   localparam longint unsigned CUTOFF_CYCLES_L = (CUTOFF_TIME_US * 64'd1000000) / CLK_PERIOD_PS;

   // drive operating states
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RUN,
      ST_DECEL,
      ST_COAST,
      ST_LOCKED
   } drive_state_t;

   // operator commands
   typedef struct packed {
      logic start;
      logic stop;
   } drive_cmd_t;

   // status toward the drive
   typedef struct packed {
      logic power_on;
      logic decel;
      logic trip;
      logic fault_latch;
   } drive_stat_t;

endpackage : torque_cutoff_pkg
